// *** dv/fcd_host_model.sv ***
// host bus model that drives the flash pins
`timescale 1ns/1ns
module fcd_host_model (
  input  wire logic        clk,
  output logic      [3:0]  pins,
  output logic      [15:0] addr,
  output logic      [15:0] dq
);
  // pins are {ce_n, we_n, oe_n, adv_n}
  initial begin
    pins = 4'hf;
    addr = 16'h0000;
    dq   = 16'h0000;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // phases of 4 clocks: the pin synchronisers need 2 to see a level
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input bit we_first);
    @(posedge clk);
    pins <= 4'h2;
    addr <= a;
    dq   <= d;
    hold(4);
    pins <= we_first ? 4'h6 : 4'hb;
    hold(1);
    // released bus has no pull: show the inverse so late capture is seen
    dq   <= ~d;
    addr <= ~a;
    hold(3);
    pins <= 4'hf;
    hold(6);
  endtask

  // one read strobe on the chosen pins, then back to idle
  task automatic pulse(input logic [3:0] p);
    @(posedge clk);
    pins <= p;
    hold(4);
    pins <= 4'hf;
    hold(6);
  endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench for the flash command decoder
`timescale 1ns/1ns
module tb import fcd_pkg::*;;
  logic        clk;
  logic        nrst;
  logic        sync_read;
  logic        eng_busy;
  logic [6:0]  eng_set;
  logic [4:0]  buf_raddr;
  logic [3:0]  pins;
  logic [15:0] addr;
  logic [15:0] dq;
  logic [1:0]  read_mode;
  logic        dq_wide;
  logic [7:0]  status_out;
  logic        pgm_start;
  logic [1:0]  pgm_kind;
  logic [15:0] pgm_addr;
  logic [15:0] pgm_data;
  logic [4:0]  pgm_words;
  logic        suspend_req;
  logic        fact_active;
  logic        fact_word;
  logic [15:0] buf_rdata;
  int          busy_cnt;
  int          n_start;
  int          n_susp;
  int          n_fact;
  int          checks;
  int          miscompares;
  bit          alt;

  fcd_host_model u_host (.clk(clk), .pins(pins), .addr(addr), .dq(dq));

  fcd_top u_dut (
    .CORE_CLK(clk), .NRST(nrst), .CE_N(pins[PIN_CE]), .WE_N(pins[PIN_WE]),
    .OE_N(pins[PIN_OE]), .ADV_N(pins[PIN_ADV]), .ADDR(addr), .DQ_IN(dq),
    .SYNC_READ(sync_read), .ENG_BUSY(eng_busy), .ENG_STAT_SET(eng_set),
    .BUF_RADDR(buf_raddr), .READ_MODE(read_mode), .DQ_WIDE(dq_wide),
    .STATUS_OUT(status_out), .PGM_START(pgm_start), .PGM_KIND(pgm_kind),
    .PGM_ADDR(pgm_addr), .PGM_DATA(pgm_data), .PGM_WORDS(pgm_words),
    .SUSPEND_REQ(suspend_req), .FACT_ACTIVE(fact_active),
    .FACT_WORD(fact_word), .BUF_RDATA(buf_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----
  // engine stand-in: busy from the edge that samples the start pulse
  // ----
  always @(posedge clk) begin
    if (pgm_start === 1'b1) begin
      eng_busy <= 1'b1;
      busy_cnt <= 120;
    end else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
    else eng_busy <= 1'b0;
    if (pgm_start === 1'b1) n_start <= n_start + 1;
    if (suspend_req === 1'b1) n_susp <= n_susp + 1;
    if (fact_word === 1'b1) n_fact <= n_fact + 1;
  end

  // wide enough for kind, address and data packed together
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // command at a varying address with junk in the upper byte
  task automatic cmd(input logic [7:0] c);
    alt = ~alt;
    u_host.wr({8'h3c, c}, {8'ha5, c}, alt);
    #5;
  endtask

  task automatic rd(input logic [3:0] p);
    u_host.pulse(p);
    #5;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (eng_busy && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (eng_busy) begin
      miscompares++;
      test_done();
    end
    repeat (3) @(posedge clk);
    #5;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_modes;
    logic [7:0] codes [4];
    codes = '{CMD_READ_ARRAY, CMD_READ_STATUS, CMD_READ_IDENT, CMD_READ_QUERY};
    for (int i = 0; i < 4; i++) begin
      cmd(codes[i]);
      chk(read_mode, i);
      chk(dq_wide, (i == 0 || i == 2));
    end
    cmd(8'h33);
    cmd(CMD_CONFIRM);
    chk(read_mode, RM_QUERY);
    chk(n_start, 0);
  endtask

  task automatic t_word(input logic [7:0] setup);
    int s0;
    int u0;
    s0 = n_start;
    u0 = n_susp;
    cmd(setup);
    chk(read_mode, RM_STATUS);
    u_host.wr(16'h1234, 16'hbeef, setup[4]);
    #5;
    chk(n_start, s0 + 1);
    chk({pgm_kind, pgm_addr, pgm_data}, {PK_WORD, 16'h1234, 16'hbeef});
    cmd(CMD_READ_ARRAY);
    chk(read_mode, RM_STATUS);
    cmd(CMD_SUSPEND);
    chk(n_susp, u0 + 1);
    rd(4'h5);
    chk(status_out[7], 1'b0);
    wait_idle();
    chk(status_out[7], 1'b0);
    rd(4'hd);
    chk(status_out[7], 1'b1);
    chk(read_mode, RM_STATUS);
    cmd(CMD_READ_ARRAY);
    chk(read_mode, RM_ARRAY);
  endtask

  task automatic set_err(input logic [6:0] b);
    @(posedge clk);
    eng_set <= b;
    @(posedge clk);
    eng_set <= 7'h00;
  endtask

  task automatic t_err;
    set_err(7'h02);
    rd(4'he);
    chk(status_out, 8'h80);
    rd(4'hd);
    chk(status_out, 8'h82);
    cmd(CMD_READ_ARRAY);
    rd(4'hd);
    chk(status_out, 8'h82);
    cmd(CMD_CLR_STATUS);
    rd(4'hd);
    chk(status_out, 8'h80);
    sync_read <= 1'b1;
    set_err(7'h04);
    rd(4'hd);
    chk(status_out, 8'h80);
    rd(4'he);
    chk(status_out, 8'h84);
    cmd(CMD_CLR_STATUS);
    sync_read <= 1'b0;
    rd(4'hd);
    chk(status_out, 8'h80);
  endtask

  task automatic t_buf(input int n);
    int s0;
    s0 = n_start;
    cmd(CMD_BUF_SETUP);
    u_host.wr(16'h0040, 16'(n - 1), 1'b1);
    for (int i = 0; i < n; i++) u_host.wr(16'h0040 + 16'(i), {~8'(i), 8'(i)}, i[0]);
    u_host.wr(16'h2222, {8'ha5, CMD_CONFIRM}, 1'b0);
    #5;
    chk(n_start, s0 + 1);
    chk({pgm_kind, pgm_words, pgm_addr}, {PK_BUFFER, 5'(n - 1), 16'h2222});
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      buf_raddr <= 5'(i);
      repeat (2) @(posedge clk);
      #5;
      chk(buf_rdata, {~8'(i), 8'(i)});
    end
    wait_idle();
    cmd(CMD_READ_ARRAY);
  endtask

  task automatic t_seq;
    int s0;
    s0 = n_start;
    cmd(CMD_BUF_SETUP);
    u_host.wr(16'h0000, 16'h0000, 1'b0);
    u_host.wr(16'h0001, 16'h1111, 1'b1);
    cmd(8'h33);
    rd(4'hd);
    chk(status_out, 8'hb0);
    cmd(CMD_CLR_STATUS);
    cmd(CMD_FACT_SETUP);
    cmd(CMD_READ_STATUS);
    rd(4'hd);
    chk(status_out, 8'hb0);
    chk(n_start, s0);
    cmd(CMD_CLR_STATUS);
    cmd(CMD_READ_ARRAY);
  endtask

  task automatic t_fact;
    int s0;
    int f0;
    s0 = n_start;
    f0 = n_fact;
    cmd(CMD_FACT_SETUP);
    chk(n_start, s0);
    u_host.wr(16'h0abc, {8'h77, CMD_CONFIRM}, 1'b1);
    #5;
    chk(n_start, s0 + 1);
    chk({pgm_kind, pgm_addr, pgm_data}, {PK_FACTORY, 16'h0abc, 16'h77d0});
    chk(fact_active, 1'b1);
    cmd(CMD_READ_ARRAY);
    cmd(CMD_READ_IDENT);
    chk(n_fact, f0 + 2);
    chk(read_mode, RM_STATUS);
    wait_idle();
    chk(fact_active, 1'b0);
    cmd(CMD_READ_ARRAY);
  endtask

  initial begin
    nrst = 1'b0;
    sync_read = 1'b0;
    eng_busy = 1'b0;
    eng_set = 7'h00;
    buf_raddr = 5'h00;
    busy_cnt = 0;
    n_start = 0;
    n_susp = 0;
    n_fact = 0;
    checks = 0;
    miscompares = 0;
    alt = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #5;
    chk({read_mode, dq_wide, status_out}, {RM_ARRAY, 1'b1, 8'h80});
    t_modes();
    t_word(CMD_WORD_SETUP);
    t_word(CMD_WORD_ALT);
    t_err();
    t_buf(4);
    t_buf(32);
    t_seq();
    t_fact();
    test_done();
  end
endmodule

// *** src/fcd_buf_if.sv ***
// program buffer port bundle between decoder and buffer memory
`timescale 1ns/1ns
interface fcd_buf_if #(parameter int AW = 5, parameter int DW = 16);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** src/fcd_buf_mem.sv ***
// program buffer memory with registered read data
`timescale 1ns/1ns
module fcd_buf_mem #(
  parameter int WORDS = 32,
  parameter int AW    = 5,
  parameter int DW    = 16
) (
  input wire logic CORE_CLK,
  fcd_buf_if.mem   bus
);

  logic [DW-1:0] mem [WORDS];

  // no reset on the array: contents are only valid once loaded
  always_ff @(posedge CORE_CLK) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
    bus.rdata <= mem[bus.raddr];
  end

endmodule

// *** src/fcd_pkg.sv ***
// constants and types shared by the flash command decoder
package fcd_pkg;

  // ----------------------------------------------------------------
  // command codes, matched on the low data byte
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_IDENT  = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY  = 8'h98;
  localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_WORD_SETUP  = 8'h40;
  localparam logic [7:0] CMD_WORD_ALT    = 8'h10;
  localparam logic [7:0] CMD_BUF_SETUP   = 8'he8;
  localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
  localparam logic [7:0] CMD_FACT_SETUP  = 8'h80;
  localparam logic [7:0] CMD_SUSPEND     = 8'hb0;

  // ----------------------------------------------------------------
  // status value layout and reset
  // ----------------------------------------------------------------
  localparam logic [7:0] STAT_RESET     = 8'h80;
  localparam logic       READY_RESET    = 1'h1;
  localparam logic [6:0] ERR_RESET      = 7'h00;
  localparam logic [6:0] ERR_CLR_MASK   = 7'h7f;
  localparam logic [6:0] ERR_SEQ_BITS   = 7'h30;

  // ----------------------------------------------------------------
  // sizes and pin vector positions
  // ----------------------------------------------------------------
  localparam int FCD_ADDR_W   = 16;
  localparam int FCD_DATA_W   = 16;
  localparam int FCD_BUF_WORDS = 32;
  localparam int FCD_BUF_AW   = 5;
  localparam int PIN_CE       = 3;
  localparam int PIN_WE       = 2;
  localparam int PIN_OE       = 1;
  localparam int PIN_ADV      = 0;
  localparam logic [3:0] PINS_IDLE = 4'hf;

  typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_IDENT, RM_QUERY} fcd_rmode_t;
  typedef enum logic [1:0] {PK_WORD, PK_BUFFER, PK_FACTORY} fcd_kind_t;

endpackage

// *** src/fcd_top.sv ***
// command front end of a parallel flash: read modes and program sequencing
`timescale 1ns/1ns
module fcd_top import fcd_pkg::*; #(
  parameter int ADDR_W = FCD_ADDR_W
) (
  input  wire logic              CORE_CLK,
  input  wire logic              NRST,
  input  wire logic              CE_N,
  input  wire logic              WE_N,
  input  wire logic              OE_N,
  input  wire logic              ADV_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [15:0]       DQ_IN,
  input  wire logic              SYNC_READ,
  input  wire logic              ENG_BUSY,
  input  wire logic [6:0]        ENG_STAT_SET,
  input  wire logic [4:0]        BUF_RADDR,
  output logic      [1:0]        READ_MODE,
  output logic                   DQ_WIDE,
  output logic      [7:0]        STATUS_OUT,
  output logic                   PGM_START,
  output logic      [1:0]        PGM_KIND,
  output logic      [ADDR_W-1:0] PGM_ADDR,
  output logic      [15:0]       PGM_DATA,
  output logic      [4:0]        PGM_WORDS,
  output logic                   SUSPEND_REQ,
  output logic                   FACT_ACTIVE,
  output logic                   FACT_WORD,
  output logic      [15:0]       BUF_RDATA
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_WORD_ARM, ST_BUF_COUNT, ST_BUF_LOAD,
    ST_BUF_CONFIRM, ST_FACT_ARM, ST_BUSY, ST_FACTORY
  } fcd_state_t;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0]        pin_s1;
  logic [3:0]        pin_s2;
  logic [3:0]        pin_q;
  logic [ADDR_W-1:0] addr_s1;
  logic [ADDR_W-1:0] addr_s2;
  logic [15:0]       dq_s1;
  logic [15:0]       dq_s2;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      pin_s1  <= PINS_IDLE;
      pin_s2  <= PINS_IDLE;
      pin_q   <= PINS_IDLE;
      addr_s1 <= '0;
      addr_s2 <= '0;
      dq_s1   <= '0;
      dq_s2   <= '0;
    end else begin
      pin_s1  <= {CE_N, WE_N, OE_N, ADV_N};
      pin_s2  <= pin_s1;
      pin_q   <= pin_s2;
      addr_s1 <= ADDR;
      addr_s2 <= addr_s1;
      dq_s1   <= DQ_IN;
      dq_s2   <= dq_s1;
    end
  end

  // ----------------------------------------------------------------
  // write cycle detection and latching
  // ----------------------------------------------------------------
  wire ce_low  = !pin_s2[PIN_CE];
  wire we_low  = !pin_s2[PIN_WE];
  wire oe_high = pin_s2[PIN_OE];
  wire wr_act  = ce_low && we_low && oe_high;
  logic wr_act_q;
  // write ends on whichever of the two strobes rises first
  wire wr_done = wr_act_q && (pin_s2[PIN_WE] || pin_s2[PIN_CE]);
  wire ce_rise  = pin_s2[PIN_CE] && !pin_q[PIN_CE];
  wire oe_rise  = pin_s2[PIN_OE] && !pin_q[PIN_OE];
  wire adv_rise = pin_s2[PIN_ADV] && !pin_q[PIN_ADV];

  logic [ADDR_W-1:0] lat_addr;
  logic [15:0]       lat_data;

  // keep the last value seen while the write was active, so that the
  // edge that closes the cycle never contributes its own data
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      wr_act_q <= 1'b0;
      lat_addr <= '0;
      lat_data <= '0;
    end else begin
      wr_act_q <= wr_act;
      if (wr_act) begin
        lat_addr <= addr_s2;
        lat_data <= dq_s2;
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // address plays no part in matching a command
  wire [7:0] cmd       = lat_data[7:0];
  wire is_array   = cmd == CMD_READ_ARRAY;
  wire is_status  = cmd == CMD_READ_STATUS;
  wire is_ident   = cmd == CMD_READ_IDENT;
  wire is_query   = cmd == CMD_READ_QUERY;
  wire is_clear   = cmd == CMD_CLR_STATUS;
  wire is_wsetup  = (cmd == CMD_WORD_SETUP) || (cmd == CMD_WORD_ALT);
  wire is_bsetup  = cmd == CMD_BUF_SETUP;
  wire is_fsetup  = cmd == CMD_FACT_SETUP;
  wire is_confirm = cmd == CMD_CONFIRM;
  wire is_suspend = cmd == CMD_SUSPEND;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  fcd_state_t state;
  fcd_state_t next_state;
  fcd_rmode_t read_mode;
  fcd_rmode_t next_rmode;
  fcd_kind_t  next_kind;
  logic       next_start;
  logic       next_susp;
  logic       seq_err;
  logic       clr_hit;
  logic       buf_we;
  logic       fact_wr;
  logic [4:0] words;
  logic [4:0] ld_idx;

  always_comb begin
    next_state = state;
    next_rmode = read_mode;
    next_kind  = PK_WORD;
    next_start = 1'b0;
    next_susp  = 1'b0;
    seq_err    = 1'b0;
    clr_hit    = 1'b0;
    buf_we     = 1'b0;
    fact_wr    = 1'b0;
    if (wr_done) begin
      unique case (state)
        ST_IDLE: begin
          if (is_array) begin
            next_rmode = RM_ARRAY;
          end else if (is_status) begin
            next_rmode = RM_STATUS;
          end else if (is_ident) begin
            next_rmode = RM_IDENT;
          end else if (is_query) begin
            next_rmode = RM_QUERY;
          end else if (is_clear) begin
            clr_hit = 1'b1;
          end else if (is_wsetup) begin
            next_state = ST_WORD_ARM;
            next_rmode = RM_STATUS;
          end else if (is_bsetup) begin
            next_state = ST_BUF_COUNT;
            next_rmode = RM_STATUS;
          end else if (is_fsetup) begin
            next_state = ST_FACT_ARM;
            next_rmode = RM_STATUS;
          end
        end
        ST_WORD_ARM: begin
          next_start = 1'b1;
          next_state = ST_BUSY;
        end
        ST_BUF_COUNT: begin
          next_state = ST_BUF_LOAD;
        end
        ST_BUF_LOAD: begin
          buf_we = 1'b1;
          if (ld_idx == words) begin
            next_state = ST_BUF_CONFIRM;
          end
        end
        ST_BUF_CONFIRM: begin
          if (is_confirm) begin
            next_start = 1'b1;
            next_kind  = PK_BUFFER;
            next_state = ST_BUSY;
          end else begin
            seq_err    = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_FACT_ARM: begin
          if (is_confirm) begin
            next_start = 1'b1;
            next_kind  = PK_FACTORY;
            next_state = ST_FACTORY;
          end else begin
            seq_err    = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_BUSY: begin
          if (is_status) begin
            next_rmode = RM_STATUS;
          end else if (is_suspend) begin
            next_susp = 1'b1;
          end
        end
        ST_FACTORY: begin
          fact_wr = 1'b1;
        end
      endcase
    end else if ((state == ST_BUSY || state == ST_FACTORY) && !PGM_START && !ENG_BUSY) begin
      // read mode stays on status until the host selects array, ident or query
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state     <= ST_IDLE;
      read_mode <= RM_ARRAY;
    end else begin
      state     <= next_state;
      read_mode <= next_rmode;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      PGM_START   <= 1'b0;
      PGM_KIND    <= PK_WORD;
      PGM_ADDR    <= '0;
      PGM_DATA    <= '0;
      SUSPEND_REQ <= 1'b0;
      FACT_WORD   <= 1'b0;
    end else begin
      PGM_START   <= next_start;
      SUSPEND_REQ <= next_susp;
      FACT_WORD   <= fact_wr;
      if (next_start) begin
        PGM_KIND <= next_kind;
        PGM_ADDR <= lat_addr;
        PGM_DATA <= lat_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // program buffer
  // ----------------------------------------------------------------
  // count word carries words minus one, so a full load of 32 fits 5 bits
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      words  <= '0;
      ld_idx <= '0;
    end else begin
      if (wr_done && state == ST_BUF_COUNT) begin
        words  <= lat_data[FCD_BUF_AW-1:0];
        ld_idx <= '0;
      end else if (next_start) begin
        ld_idx <= '0;
      end else if (buf_we || fact_wr) begin
        ld_idx <= ld_idx + 5'h01;
      end
    end
  end

  assign PGM_WORDS = words;

  fcd_buf_if #(.AW(FCD_BUF_AW), .DW(FCD_DATA_W)) buf_bus ();

  assign buf_bus.we    = buf_we || fact_wr;
  assign buf_bus.waddr = ld_idx;
  assign buf_bus.wdata = lat_data;
  assign buf_bus.raddr = BUF_RADDR;
  assign BUF_RDATA     = buf_bus.rdata;

  fcd_buf_mem #(.WORDS(FCD_BUF_WORDS), .AW(FCD_BUF_AW), .DW(FCD_DATA_W)) u_buf (
    .CORE_CLK (CORE_CLK),
    .bus      (buf_bus.mem)
  );

  // ----------------------------------------------------------------
  // status value and its refresh
  // ----------------------------------------------------------------
  logic       ready;
  logic [6:0] err;
  logic [7:0] status_shown;
  // engine set beats a clear arriving in the same cycle
  wire [6:0] next_err = (err & ~(clr_hit ? ERR_CLR_MASK : 7'h00))
                        | ENG_STAT_SET | (seq_err ? ERR_SEQ_BITS : 7'h00);
  wire refresh = SYNC_READ ? (ce_rise || adv_rise) : (ce_rise || oe_rise);

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ready        <= READY_RESET;
      err          <= ERR_RESET;
      status_shown <= STAT_RESET;
    end else begin
      ready <= !ENG_BUSY;
      err   <= next_err;
      if (refresh) begin
        status_shown <= {ready, err};
      end
    end
  end

  assign READ_MODE   = read_mode;
  assign DQ_WIDE     = (read_mode == RM_ARRAY) || (read_mode == RM_IDENT);
  assign STATUS_OUT  = status_shown;
  assign FACT_ACTIVE = state == ST_FACTORY;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  property p_array;
    wr_done && state == ST_IDLE && is_array |=> read_mode == RM_ARRAY && DQ_WIDE;
  endproperty
  a_array: assert property (p_array) else $error("ff did not select array");

  property p_status;
    wr_done && (state == ST_IDLE || state == ST_BUSY) && is_status
      |=> read_mode == RM_STATUS && !DQ_WIDE;
  endproperty
  a_status: assert property (p_status) else $error("70 did not select status");

  property p_query;
    wr_done && state == ST_IDLE && is_query |=> read_mode == RM_QUERY ##1 !DQ_WIDE;
  endproperty
  a_query: assert property (p_query) else $error("98 did not select query");

  property p_err_sticky;
    !clr_hit |=> (($past(err) & ~err) == 7'h00);
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error bit cleared");

  property p_word_start;
    wr_done && state == ST_WORD_ARM
      |=> PGM_START && PGM_KIND == PK_WORD && PGM_DATA == $past(lat_data) ##1 !PGM_START;
  endproperty
  a_word_start: assert property (p_word_start) else $error("word program not started");

  property p_busy_filter;
    wr_done && state == ST_BUSY && !is_status |=> $stable(read_mode) && !PGM_START;
  endproperty
  a_busy_filter: assert property (p_busy_filter) else $error("command obeyed in busy");

  property p_refresh;
    !refresh |=> $stable(status_shown);
  endproperty
  a_refresh: assert property (p_refresh) else $error("status changed without toggle");

  property p_alt_setup;
    wr_done && state == ST_IDLE && cmd == CMD_WORD_ALT |=> state == ST_WORD_ARM;
  endproperty
  a_alt_setup: assert property (p_alt_setup) else $error("10 not taken as setup");

  property p_fact_hold;
    state == ST_FACTORY && wr_done |=> $stable(read_mode) && state != ST_IDLE;
  endproperty
  a_fact_hold: assert property (p_fact_hold) else $error("factory mode obeyed command");

  c_word: cover property (state == ST_WORD_ARM && wr_done ##1 PGM_START);
  c_buffer: cover property (state == ST_BUF_CONFIRM && wr_done && is_confirm);
  c_factory: cover property (state == ST_FACT_ARM ##1 state == ST_FACTORY);
  c_seq_err: cover property (seq_err);

endmodule
